// ### include/ptm_defs.svh
// Constants of the periodic timer: register indices, field positions, reset values.
// Assumes the timer top module includes this file by its bare name; the timer package does not include it.
`ifndef PTM_DEFS_SVH
`define PTM_DEFS_SVH

// Register indices; the byte address is four times the index.
`define PTM_IDX_CTRL_A  3'h0
`define PTM_IDX_CTRL_B  3'h1
`define PTM_IDX_CNT_LO  3'h2
`define PTM_IDX_CNT_HI  3'h3
`define PTM_IDX_CMPA_LO 3'h4
`define PTM_IDX_CMPA_HI 3'h5
`define PTM_IDX_PER_LO  3'h6
`define PTM_IDX_PER_HI  3'h7

// Field positions in timer_control_a and timer_control_b.
`define PTM_A_PAUSE   7
`define PTM_A_EN      3
`define PTM_A_MASK    8'hF8
`define PTM_B_OC      3
`define PTM_B_POL     2
`define PTM_B_CAPTS   1
`define PTM_B_CLRSEL  0

// Reset values.
`define PTM_RST_BYTE  8'h00
`define PTM_RST_WORD  10'h000

// Clock select codes and prescaler terminal values.
`define PTM_CK_SYS4   3'h0
`define PTM_CK_SYS    3'h1
`define PTM_CK_H16    3'h2
`define PTM_CK_H64    3'h3
`define PTM_CK_SUB0   3'h4
`define PTM_CK_SUB1   3'h5
`define PTM_CK_EXTR   3'h6
`define PTM_CK_EXTF   3'h7
`define PTM_DIV4_END  2'h3
`define PTM_DIV16_END 4'hF
`define PTM_DIV64_END 6'h3F

// Pin function codes.
`define PTM_FN_00     2'h0
`define PTM_FN_01     2'h1
`define PTM_FN_10     2'h2
`define PTM_FN_11     2'h3

`endif

// ### include/ptm_pkg.sv
// Types of the periodic timer: operating modes and the module state record.
// Assumes nothing beyond the constants header.
package ptm_pkg;
    // Operating modes in mode field order.
    typedef enum logic [1:0] {PTM_CMP, PTM_CAP, PTM_PWM, PTM_TMR} ptm_mode_t;

    // Whole state of the timer top module.
    typedef struct packed {
        logic [7:0]  ctrl_a;
        logic [7:0]  ctrl_b;
        logic [9:0]  cnt;
        logic [9:0]  cmp_a;
        logic [9:0]  period;
        logic        en_prev;
        logic        out_lvl;
        logic        pin;
        logic [5:0]  presc;
        logic [2:0]  ext_s;
        logic [2:0]  cap_s;
        logic [2:0]  sub_s;
        logic        wr_pend;
        logic [2:0]  wr_idx;
        logic [31:0] hrdata;
    } ptm_state_t;
endpackage

// ### logic/ptm_top.sv
// Periodic timer with its control and data registers on an AHB-Lite slave port.
// Assumes one clock; pins arrive asynchronously and the high clock equals the system clock.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "ptm_defs.svh"

module ptm_top (
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic [31:0]      hrdata_out,
    input  wire logic        external_clock_pin_in,
    input  wire logic        capture_input_pin_in,
    input  wire logic        sub_clock_in,
    output logic             timer_output_pin_out
);
    import ptm_pkg::*;

    ptm_state_t r;
    ptm_state_t n;
    ptm_mode_t  mode;
    logic       en;
    logic       en_rise;
    logic       run;
    logic       tick;
    logic       single;
    logic       a_hit;
    logic       p_hit;
    logic       clr_hit;
    logic       cap_edge;
    logic       trg_rise;
    logic       trg_fall;
    logic       ext_rise;
    logic       ext_fall;
    logic       sub_rise;
    logic       take;
    logic       pwm_act;
    logic       lvl;
    logic [9:0] cnt_inc;
    logic [1:0] fn;

    // Read multiplexer; unused upper bits stay zero.
    function automatic logic [31:0] rd_word(input ptm_state_t s, input logic [2:0] idx);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (idx)
            `PTM_IDX_CTRL_A:  w[7:0] = s.ctrl_a & `PTM_A_MASK;
            `PTM_IDX_CTRL_B:  w[7:0] = s.ctrl_b;
            `PTM_IDX_CNT_LO:  w[7:0] = s.cnt[7:0];
            `PTM_IDX_CNT_HI:  w[1:0] = s.cnt[9:8];
            `PTM_IDX_CMPA_LO: w[7:0] = s.cmp_a[7:0];
            `PTM_IDX_CMPA_HI: w[1:0] = s.cmp_a[9:8];
            `PTM_IDX_PER_LO:  w[7:0] = s.period[7:0];
            `PTM_IDX_PER_HI:  w[1:0] = s.period[9:8];
            default:          w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // The slave never stalls and always answers OKAY.
    assign hreadyout_out        = 1'b1;
    assign hresp_out            = 1'b0;
    assign hrdata_out           = r.hrdata;
    assign timer_output_pin_out = r.pin;

    // Decode of control fields and edge detectors on the second synchroniser stage.
    always_comb begin
        mode     = ptm_mode_t'(r.ctrl_b[7:6]);
        fn       = r.ctrl_b[5:4];
        en       = r.ctrl_a[`PTM_A_EN];
        en_rise  = en & ~r.en_prev;
        run      = en & ~r.ctrl_a[`PTM_A_PAUSE] & ~en_rise;
        single   = (mode == PTM_PWM) && (fn == `PTM_FN_11);
        ext_rise = r.ext_s[1] & ~r.ext_s[2];
        ext_fall = ~r.ext_s[1] & r.ext_s[2];
        sub_rise = r.sub_s[1] & ~r.sub_s[2];
        take     = hsel_in & hready_in & htrans_in[1];
        cnt_inc  = r.cnt + 10'h001;
    end

    // Counter clock selection from the system clock, the prescaler, the sub clock or the external pin.
    always_comb begin
        unique case (r.ctrl_a[6:4])
            `PTM_CK_SYS4: tick = (r.presc[1:0] == `PTM_DIV4_END);
            `PTM_CK_SYS:  tick = 1'b1;
            `PTM_CK_H16:  tick = (r.presc[3:0] == `PTM_DIV16_END);
            `PTM_CK_H64:  tick = (r.presc == `PTM_DIV64_END);
            `PTM_CK_SUB0: tick = sub_rise;
            `PTM_CK_SUB1: tick = sub_rise;
            `PTM_CK_EXTR: tick = ext_rise;
            `PTM_CK_EXTF: tick = ext_fall;
        endcase
    end

    // Comparators on the next count; a zero value never matches so the counter overflows.
    always_comb begin
        a_hit = run & tick & (cnt_inc == r.cmp_a) & (r.cmp_a != `PTM_RST_WORD);
        p_hit = run & tick & (cnt_inc == r.period) & (r.period != `PTM_RST_WORD);
        unique case (mode)
            PTM_CMP, PTM_TMR: clr_hit = r.ctrl_b[`PTM_B_CLRSEL] ? a_hit : p_hit;
            PTM_PWM:          clr_hit = single ? 1'b0 : p_hit;
            PTM_CAP:          clr_hit = p_hit;
        endcase
    end

    // Capture trigger source and edge selection.
    always_comb begin
        trg_rise = r.ctrl_b[`PTM_B_CAPTS] ? ext_rise : (r.cap_s[1] & ~r.cap_s[2]);
        trg_fall = r.ctrl_b[`PTM_B_CAPTS] ? ext_fall : (~r.cap_s[1] & r.cap_s[2]);
        unique case (fn)
            `PTM_FN_00: cap_edge = trg_rise;
            `PTM_FN_01: cap_edge = trg_fall;
            `PTM_FN_10: cap_edge = trg_rise | trg_fall;
            `PTM_FN_11: cap_edge = 1'b0;
        endcase
        cap_edge = cap_edge & en & (mode == PTM_CAP);
    end

    // Output pin level before polarity, chosen by mode and pin function.
    always_comb begin
        pwm_act = (r.cnt < r.cmp_a);
        unique case (fn)
            `PTM_FN_00: lvl = ~r.ctrl_b[`PTM_B_OC];
            `PTM_FN_01: lvl = r.ctrl_b[`PTM_B_OC];
            `PTM_FN_10: lvl = pwm_act ? r.ctrl_b[`PTM_B_OC] : ~r.ctrl_b[`PTM_B_OC];
            `PTM_FN_11: lvl = en ? r.ctrl_b[`PTM_B_OC] : ~r.ctrl_b[`PTM_B_OC];
        endcase
        if (mode == PTM_CMP) begin
            lvl = r.out_lvl;
        end
    end

    // Next state: synchronisers, bus access, counter, compare output and capture.
    always_comb begin
        n       = r;
        n.ext_s = {r.ext_s[1:0], external_clock_pin_in};
        n.cap_s = {r.cap_s[1:0], capture_input_pin_in};
        n.sub_s = {r.sub_s[1:0], sub_clock_in};
        n.presc = r.presc + 6'h01;
        n.en_prev = en;
        // Data phase of a write; counter bytes and unused bits take nothing.
        if (r.wr_pend) begin
            case (r.wr_idx)
                `PTM_IDX_CTRL_A:  n.ctrl_a = hwdata_in[7:0] & `PTM_A_MASK;
                `PTM_IDX_CTRL_B:  n.ctrl_b = hwdata_in[7:0];
                `PTM_IDX_CMPA_LO: n.cmp_a[7:0] = hwdata_in[7:0];
                `PTM_IDX_CMPA_HI: n.cmp_a[9:8] = hwdata_in[1:0];
                `PTM_IDX_PER_LO:  n.period[7:0] = hwdata_in[7:0];
                `PTM_IDX_PER_HI:  n.period[9:8] = hwdata_in[1:0];
                default:          n.ctrl_a = n.ctrl_a;
            endcase
        end
        // Counter start, stop, pause, count and clear.
        if (en_rise) begin
            n.cnt = `PTM_RST_WORD;
            if (mode == PTM_CMP || mode == PTM_PWM) begin
                n.out_lvl = r.ctrl_b[`PTM_B_OC];
            end
        end else if (run && tick) begin
            n.cnt = clr_hit ? `PTM_RST_WORD : cnt_inc;
        end
        // Compare match output action; equal levels leave the pin as it is.
        if (a_hit && mode == PTM_CMP) begin
            unique case (fn)
                `PTM_FN_00: n.out_lvl = r.out_lvl;
                `PTM_FN_01: n.out_lvl = 1'b0;
                `PTM_FN_10: n.out_lvl = 1'b1;
                `PTM_FN_11: n.out_lvl = ~r.out_lvl;
            endcase
        end
        // Single pulse: clock pin edge starts it, compare A match ends it.
        if (single && ext_rise && !en) begin
            n.ctrl_a[`PTM_A_EN] = 1'b1;
        end
        if (single && a_hit) begin
            n.ctrl_a[`PTM_A_EN] = 1'b0;
        end
        // Captured count wins over a software write in the same cycle.
        if (cap_edge) begin
            n.cmp_a = r.cnt;
        end
        // Timer output pin, inverted by the polarity bit; idle low when unused.
        if (mode == PTM_CAP || mode == PTM_TMR) begin
            n.pin = 1'b0;
        end else begin
            n.pin = lvl ^ r.ctrl_b[`PTM_B_POL];
        end
        // Address phase: latch writes, sample read data after this cycle's write.
        n.wr_pend = take & hwrite_in & (haddr_in[31:5] == 27'h0);
        n.wr_idx  = haddr_in[4:2];
        n.hrdata  = 32'h0000_0000;
        if (take && !hwrite_in && haddr_in[31:5] == 27'h0) begin
            n.hrdata = rd_word(n, haddr_in[4:2]);
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_off_two;
        !r.ctrl_a[`PTM_A_EN] ##1 !r.ctrl_a[`PTM_A_EN];
    endsequence

    sequence s_start_cmp;
        en_rise && mode == PTM_CMP;
    endsequence

    a_sys_tick: assert property (r.ctrl_a[6:4] == `PTM_CK_SYS |-> tick)
        else $error("System clock selection does not tick every cycle.");
    a_start_zero: assert property (en_rise |=> r.cnt == `PTM_RST_WORD)
        else $error("Counter not zeroed on enable rising edge.");
    a_stop_hold: assert property (s_off_two |-> $stable(r.cnt))
        else $error("Counter moved while switched off.");
    a_init_level: assert property (s_start_cmp |=> r.out_lvl == $past(r.ctrl_b[`PTM_B_OC]))
        else $error("Output not restored to initial level.");
    a_unused_zero: assert property (r.hrdata[31:8] == 24'h0)
        else $error("Unused read data bits not zero.");
    a_cmp_high: assert property (a_hit && mode == PTM_CMP && fn == `PTM_FN_10 |=> r.out_lvl)
        else $error("Compare match did not drive output high.");
    a_capture_val: assert property (cap_edge |=> r.cmp_a == $past(r.cnt))
        else $error("Capture did not latch the count.");
    a_pause_hold: assert property (r.ctrl_a[`PTM_A_PAUSE] && en && r.en_prev |=> r.cnt == $past(r.cnt))
        else $error("Counter moved while paused.");
    a_period_clr: assert property (p_hit && mode == PTM_CMP && !r.ctrl_b[`PTM_B_CLRSEL]
        |=> r.cnt == `PTM_RST_WORD)
        else $error("Period match did not clear counter.");
endmodule

// ### test/ptm_pin_model.sv
// Pin-side model: external clock pin, capture pin and sub clock.
// Assumes the bench calls its tasks; levels change just after a rising edge.
`timescale 1ns/100ps
module ptm_pin_model (
    input  wire logic clk_in,
    output logic      ext_out,
    output logic      cap_out,
    output logic      sub_out
);
    // Pins idle low; the sub clock stands still between bursts.
    initial begin
        ext_out = 1'b0;
        cap_out = 1'b0;
        sub_out = 1'b0;
    end

    // Drives one pin (0 clock, 1 capture, 2 sub) and holds it for eight clocks.
    task automatic drive(input int sel, input logic lvl);
        @(posedge clk_in);
        if (sel == 0) ext_out <= lvl;
        else if (sel == 1) cap_out <= lvl;
        else sub_out <= lvl;
        repeat (8) @(posedge clk_in);
    endtask

    // Sends n whole pulses on one pin.
    task automatic pulses(input int sel, input int n);
        repeat (n) begin
            drive(sel, 1'b1);
            drive(sel, 1'b0);
        end
    endtask
endmodule

// ### test/test_ptm_top.sv
// Self-checking bench of the periodic timer: bus tasks and table-driven tests.
// Assumes ptm_top and the pin model; the bench is the only bus master.
`timescale 1ns/100ps
module test_ptm_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic        hready;
    logic        hresp;
    logic [31:0] hrdata;
    logic        ext, cap, sub, pin;
    logic [31:0] v, u;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          dv[4] = '{4, 1, 16, 64};
    logic [23:0] rw[9] = '{24'h00FFF8, 24'h04FFFF, 24'h08FF00, 24'h0CFF00, 24'h10A5A5,
                           24'h14FF03, 24'h185A5A, 24'h1CFF03, 24'h20FF00};
    logic [11:0] mt[9] = '{12'h010, 12'h18B, 12'h214, 12'h34B, 12'h28F, 12'h893, 12'h98F,
                           12'hA9B, 12'hA4B};
    logic [11:0] ct[6] = '{12'h406, 12'h505, 12'h607, 12'h704, 12'h424, 12'h422};

    // Clock of 50 ns and a cycle ceiling that cuts a hang short.
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    ptm_top dut_u (.core_clk_in(clk), .rst_in(rst), .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready),
        .hresp_out(hresp), .hrdata_out(hrdata), .external_clock_pin_in(ext), .capture_input_pin_in(cap),
        .sub_clock_in(sub), .timer_output_pin_out(pin));
    ptm_pin_model pin_u (.clk_in(clk), .ext_out(ext), .cap_out(cap), .sub_out(sub));

    // One single word transfer; read data lands in v at the closing edge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        v = hrdata;
    endtask

    // Counts a comparison and reports a mismatch.
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    // Reads one register and compares it.
    task automatic chk(input logic [7:0] a, input logic [7:0] e, input string n);
        bus(1'b0, a, 8'h00);
        cmp(n, {24'h0, e}, v);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Main sequence: registers, clock sources, output modes, single pulse, capture.
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) chk(8'(i * 4), 8'h00, "reset value");
        cmp("bus response", 32'h0, {31'h0, hresp});
        for (int i = 0; i < 9; i++) begin
            bus(1'b1, rw[i][23:16], rw[i][15:8]);
            chk(rw[i][23:16], rw[i][7:0], "write readback");
        end
        bus(1'b1, 8'h00, 8'h00);
        bus(1'b1, 8'h04, 8'h00);
        bus(1'b1, 8'h10, 8'h03);
        bus(1'b1, 8'h14, 8'h00);
        bus(1'b1, 8'h18, 8'h00);
        bus(1'b1, 8'h1C, 8'h00);
        // Every clock source: internal rates over 128 cycles, pin sources by pulses.
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, 8'h00, 8'h00);
            bus(1'b1, 8'h00, {1'b0, 3'(i), 4'h8});
            if (i < 4) begin
                repeat (128) @(posedge clk);
                bus(1'b1, 8'h00, {1'b1, 3'(i), 4'h8});
                bus(1'b0, 8'h08, 8'h00);
                checks_done++;
                if ($isunknown(v) || v < 128 / dv[i] - 1 || v > 136 / dv[i] + 1) begin
                    error_cnt++;
                    $display("[ERR] count expected near %0d seen %0d", 128 / dv[i], v);
                end
                u = v;
                repeat (20) @(posedge clk);
                chk(8'h08, u[7:0], "paused count");
            end else begin
                pin_u.pulses(i < 6 ? 2 : 0, 5);
                chk(8'h08, 8'h05, "pin clock count");
            end
        end
        // Stop keeps the value, restart clears it, pause holds and resumes.
        bus(1'b1, 8'h00, 8'h70);
        pin_u.pulses(0, 2);
        chk(8'h08, 8'h05, "stopped count");
        bus(1'b1, 8'h00, 8'hF8);
        chk(8'h08, 8'h00, "restart count");
        pin_u.pulses(0, 2);
        chk(8'h08, 8'h00, "paused count");
        bus(1'b1, 8'h00, 8'h78);
        pin_u.pulses(0, 2);
        chk(8'h08, 8'h02, "resumed count");
        // Compare and PWM rows: switched off before each change, then three pin clocks.
        for (int i = 0; i < 9; i++) begin
            bus(1'b1, 8'h00, 8'h00);
            bus(1'b1, 8'h04, mt[i][11:4]);
            bus(1'b1, 8'h00, 8'h68);
            repeat (4) @(posedge clk);
            cmp("initial pin", {31'h0, mt[i][3]}, {31'h0, pin});
            pin_u.pulses(0, 3);
            cmp("final pin", {31'h0, mt[i][2]}, {31'h0, pin});
            chk(8'h08, {6'h0, mt[i][1:0]}, "match count");
        end
        // Single pulse: software start, compare A end, then a pin trigger.
        bus(1'b1, 8'h00, 8'h00);
        bus(1'b1, 8'h14, 8'h03);
        bus(1'b1, 8'h04, 8'hB8);
        bus(1'b1, 8'h00, 8'h18);
        repeat (4) @(posedge clk);
        cmp("pulse active", 32'h1, {31'h0, pin});
        repeat (800) @(posedge clk);
        cmp("pulse ended", 32'h0, {31'h0, pin});
        chk(8'h00, 8'h10, "pulse enable");
        pin_u.pulses(0, 1);
        cmp("pin trigger", 32'h1, {31'h0, pin});
        // Capture rows with the counter paused at five.
        bus(1'b1, 8'h00, 8'h00);
        bus(1'b1, 8'h04, 8'h40);
        bus(1'b1, 8'h00, 8'h68);
        pin_u.pulses(0, 5);
        bus(1'b1, 8'h00, 8'h98);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, 8'h04, ct[i][11:4]);
            bus(1'b1, 8'h10, 8'hFF);
            pin_u.drive(int'(ct[i][3:2]), 1'b1);
            chk(8'h10, ct[i][1] ? 8'h05 : 8'hFF, "capture rise");
            bus(1'b1, 8'h10, 8'hFF);
            pin_u.drive(int'(ct[i][3:2]), 1'b0);
            chk(8'h10, ct[i][0] ? 8'h05 : 8'hFF, "capture fall");
        end
        tally_and_finish();
    end
endmodule
